/* File: rcb2_engine.sv */
// Descriptor-driven storage engine for a subaddress in the second circular ring mode.
`timescale 1ns/10ps
module rcb2_engine #(
	parameter int AW = 16,
	parameter int DW = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Command from the protocol logic.
	input wire logic cmd_valid,
	input wire logic [15:0] cmd_word,
	input wire logic cmd_broadcast,
	output logic cmd_ready,
	// Configuration.
	input wire logic [AW-1:0] desc_table_base,
	input wire logic rt_block_done_enable,
	input wire logic ext_broadcast_flag_enable,
	// Received words.
	input wire logic rx_valid,
	input wire logic [DW-1:0] rx_data,
	output logic rx_ready,
	// Words to transmit.
	output logic tx_valid,
	output logic [DW-1:0] tx_data,
	input wire logic tx_ready,
	// Message end report.
	input wire logic end_valid,
	input wire logic end_error,
	input wire logic [DW-1:0] end_info,
	input wire logic [DW-1:0] end_time_tag,
	// Shared memory port.
	output logic mem_req,
	output logic mem_we,
	output logic [AW-1:0] mem_addr,
	output logic [DW-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [DW-1:0] mem_rdata,
	// Status toward the host.
	input wire logic int_clear,
	output logic int_n,
	output logic block_done,
	output logic mode_skip,
	output logic busy
);

	rcb2_pkg::rcb2_state_type st_q;
	rcb2_pkg::rcb2_state_type st_d;
	logic tr_q;
	logic broadcast_flag_q;
	logic err_q;
	logic end_pend_q;
	logic [5:0] left_q;
	logic [AW-1:0] desc_q;
	logic [AW-1:0] orig_q;
	logic [AW-1:0] dcur_q;
	logic [AW-1:0] icur_q;
	logic [DW-1:0] ctrl_q;
	logic [DW-1:0] info_q;
	logic [DW-1:0] tag_q;
	logic cmd_take;
	logic rx_take;
	logic mem_done;
	logic end_seen;
	logic update_ok;
	logic acc_start;
	logic acc_we;
	logic [AW-1:0] acc_addr;
	logic [DW-1:0] acc_wdata;
	logic [DW-1:0] info_word;
	logic [AW-1:0] info_next;
	logic info_full;
	logic buf_in_ready;
	logic buf_push;

	assign cmd_take = cmd_valid && cmd_ready;
	assign rx_take = rx_valid && rx_ready;
	assign mem_done = mem_req && mem_ack;
	assign end_seen = end_valid || end_pend_q;
	assign update_ok = !err_q && !(tr_q && broadcast_flag_q);
	assign buf_push = mem_done && (st_q == rcb2_pkg::ST_XFER) && tr_q;

	rcb2_info_step #(
		.AW(AW)
	) u_step (
		.cursor(icur_q),
		.size_code(ctrl_q[rcb2_pkg::CTRL_SIZE_LSB +: 4]),
		.next_cursor(info_next),
		.full(info_full)
	);

	// A stall by the transmitter backs up here instead of dropping a fetched word.
	rcb2_pair_buffer #(
		.W(DW)
	) u_txbuf (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(buf_push),
		.in_data(mem_rdata),
		.in_ready(buf_in_ready),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready)
	);

	always_comb
	begin
		info_word = info_q;
		info_word[rcb2_pkg::INFO_BROADCAST_FLAG_BIT] = ext_broadcast_flag_enable && broadcast_flag_q;
	end

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			rcb2_pkg::ST_IDLE:
				if (cmd_take)
					st_d = rcb2_pkg::ST_RD_CTRL;
			rcb2_pkg::ST_RD_CTRL:
				if (mem_done)
				begin
					if (!mem_rdata[rcb2_pkg::CTRL_PINGPONG_BIT] && mem_rdata[rcb2_pkg::CTRL_RING2_BIT])
						st_d = rcb2_pkg::ST_RD_ORIG;
					else
						st_d = rcb2_pkg::ST_IDLE;
				end
			rcb2_pkg::ST_RD_ORIG:
				if (mem_done)
					st_d = rcb2_pkg::ST_RD_CUR;
			rcb2_pkg::ST_RD_CUR:
				if (mem_done)
					st_d = rcb2_pkg::ST_RD_INFO;
			rcb2_pkg::ST_RD_INFO:
				if (mem_done)
					st_d = (tr_q && broadcast_flag_q) ? rcb2_pkg::ST_WAIT_END : rcb2_pkg::ST_XFER;
			rcb2_pkg::ST_XFER:
				if (!mem_req && !rx_take)
				begin
					if (end_seen)
						st_d = rcb2_pkg::ST_WR_INFO;
					else if (left_q == 6'h00)
						st_d = rcb2_pkg::ST_WAIT_END;
				end
			rcb2_pkg::ST_WAIT_END:
				if (end_seen)
					st_d = rcb2_pkg::ST_WR_INFO;
			rcb2_pkg::ST_WR_INFO:
				if (mem_done)
					st_d = rcb2_pkg::ST_WR_TAG;
			rcb2_pkg::ST_WR_TAG:
				if (mem_done)
					st_d = update_ok ? rcb2_pkg::ST_WR_CUR : rcb2_pkg::ST_IDLE;
			rcb2_pkg::ST_WR_CUR:
				if (mem_done)
					st_d = rcb2_pkg::ST_WR_ICUR;
			rcb2_pkg::ST_WR_ICUR:
				if (mem_done)
					st_d = rcb2_pkg::ST_IDLE;
			default:
				st_d = rcb2_pkg::ST_IDLE;
		endcase
	end

	// Memory access wanted by the current state.
	always_comb
	begin
		acc_start = !mem_req;
		acc_we = 1'b1;
		acc_addr = icur_q;
		acc_wdata = info_word;
		case (st_q)
			rcb2_pkg::ST_RD_CTRL:
			begin
				acc_we = 1'b0;
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_CTRL_OFS);
			end
			rcb2_pkg::ST_RD_ORIG:
			begin
				acc_we = 1'b0;
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_ORIG_OFS);
			end
			rcb2_pkg::ST_RD_CUR:
			begin
				acc_we = 1'b0;
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_CUR_OFS);
			end
			rcb2_pkg::ST_RD_INFO:
			begin
				acc_we = 1'b0;
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_INFO_OFS);
			end
			rcb2_pkg::ST_XFER:
			begin
				// Broadcast and ordinary receive data go to the same ring.
				acc_we = !tr_q;
				acc_addr = dcur_q;
				acc_wdata = rx_data;
				if (tr_q)
					acc_start = !mem_req && (left_q != 6'h00) && buf_in_ready && !end_seen;
				else
					acc_start = rx_take;
			end
			rcb2_pkg::ST_WR_INFO:
				acc_addr = icur_q;
			rcb2_pkg::ST_WR_TAG:
			begin
				acc_addr = icur_q + AW'(1);
				acc_wdata = tag_q;
			end
			rcb2_pkg::ST_WR_CUR:
			begin
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_CUR_OFS);
				acc_wdata = DW'(info_full ? orig_q : dcur_q);
			end
			rcb2_pkg::ST_WR_ICUR:
			begin
				acc_addr = desc_q + AW'(rcb2_pkg::DESC_INFO_OFS);
				acc_wdata = DW'(info_next);
			end
			default:
				acc_start = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= rcb2_pkg::ST_IDLE;
			cmd_ready <= 1'b0;
			busy <= 1'b0;
			rx_ready <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cmd_ready <= (st_d == rcb2_pkg::ST_IDLE) && !cmd_take;
			busy <= (st_d != rcb2_pkg::ST_IDLE);
			rx_ready <= (st_q == rcb2_pkg::ST_XFER) && !tr_q && (left_q != 6'h00) && !mem_req
				&& !rx_take && !end_seen;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= '0;
		end
		else if (mem_done)
			mem_req <= 1'b0;
		else if (acc_start)
		begin
			mem_req <= 1'b1;
			mem_we <= acc_we;
			mem_addr <= acc_addr;
			mem_wdata <= acc_wdata;
		end
	end

	// Command capture and descriptor contents.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			tr_q <= 1'b0;
			broadcast_flag_q <= 1'b0;
			left_q <= rcb2_pkg::LEFT_RESET;
			desc_q <= '0;
			ctrl_q <= '0;
			orig_q <= '0;
			dcur_q <= '0;
			icur_q <= '0;
		end
		else if (cmd_take)
		begin
			tr_q <= cmd_word[rcb2_pkg::CMD_TR_BIT];
			broadcast_flag_q <= cmd_broadcast;
			if (cmd_word[rcb2_pkg::CMD_WC_LSB +: 5] == 5'h00)
				left_q <= rcb2_pkg::WC_ZERO_MEANS;
			else
				left_q <= {1'b0, cmd_word[rcb2_pkg::CMD_WC_LSB +: 5]};
			desc_q <= desc_table_base + AW'({cmd_word[rcb2_pkg::CMD_TR_BIT],
				cmd_word[rcb2_pkg::CMD_SA_LSB +: 5], 2'h0});
		end
		else if (mem_done)
		begin
			case (st_q)
				rcb2_pkg::ST_RD_CTRL:
					ctrl_q <= mem_rdata;
				rcb2_pkg::ST_RD_ORIG:
					orig_q <= AW'(mem_rdata);
				rcb2_pkg::ST_RD_CUR:
					dcur_q <= AW'(mem_rdata);
				rcb2_pkg::ST_RD_INFO:
					icur_q <= AW'(mem_rdata);
				rcb2_pkg::ST_XFER:
				begin
					dcur_q <= dcur_q + AW'(1);
					left_q <= left_q - 6'h01;
				end
				default:
					left_q <= left_q;
			endcase
		end
	end

	// The end report is a pulse; it is held here until the engine is ready for it.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			end_pend_q <= 1'b0;
			err_q <= 1'b0;
			info_q <= '0;
			tag_q <= '0;
		end
		else
		begin
			if (end_valid)
			begin
				err_q <= end_error;
				info_q <= end_info;
				tag_q <= end_time_tag;
			end
			// A report consumed in the cycle it arrives must not stay pending for the next command.
			if ((st_d == rcb2_pkg::ST_WR_INFO) && (st_q != rcb2_pkg::ST_WR_INFO))
				end_pend_q <= 1'b0;
			else if (end_valid)
				end_pend_q <= 1'b1;
		end
	end

	// Interrupt follows the last write-back so the host sees reset pointers.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			int_n <= 1'b1;
			block_done <= 1'b0;
			mode_skip <= 1'b0;
		end
		else
		begin
			block_done <= mem_done && (st_q == rcb2_pkg::ST_WR_ICUR) && info_full;
			mode_skip <= mem_done && (st_q == rcb2_pkg::ST_RD_CTRL) && (st_d == rcb2_pkg::ST_IDLE);
			if (mem_done && (st_q == rcb2_pkg::ST_WR_ICUR) && info_full
				&& ctrl_q[rcb2_pkg::CTRL_IRQ_BIT] && rt_block_done_enable)
				int_n <= 1'b0;
			else if (int_clear)
				int_n <= 1'b1;
		end
	end

	a_cmd_fetch: assert property (@(posedge core_clk) disable iff (rst)
		cmd_take |=> (st_q == rcb2_pkg::ST_RD_CTRL) ##1 (mem_req && !mem_we && mem_addr == desc_q))
		else $error("descriptor fetch did not follow the command");

	a_info_advance: assert property (@(posedge core_clk) disable iff (rst)
		$rose(mem_req) && (st_q == rcb2_pkg::ST_WR_ICUR) && !info_full
		|-> mem_wdata == DW'(icur_q + AW'(2)))
		else $error("info cursor not advanced by two");

	a_full_restore: assert property (@(posedge core_clk) disable iff (rst)
		$rose(mem_req) && (st_q == rcb2_pkg::ST_WR_ICUR) && info_full
		|-> (mem_wdata == DW'(icur_q & ~AW'(rcb2_pkg::rcb2_size_mask(ctrl_q[7:4]))))
			&& ($past(mem_wdata, 2) == DW'(orig_q) || $past(mem_wdata, 3) == DW'(orig_q)))
		else $error("full count did not restore both cursors");

	a_rx_place: assert property (@(posedge core_clk) disable iff (rst)
		rx_take && (st_q == rcb2_pkg::ST_XFER) |=> mem_req && mem_we && mem_addr == $past(dcur_q)
			&& mem_wdata == $past(rx_data))
		else $error("received word not placed at the data cursor");

	a_tx_source: assert property (@(posedge core_clk) disable iff (rst)
		$rose(mem_req) && (st_q == rcb2_pkg::ST_XFER) && tr_q |-> !mem_we && mem_addr == dcur_q)
		else $error("transmit word not read at the data cursor");

	a_info_order: assert property (@(posedge core_clk) disable iff (rst)
		(st_q == rcb2_pkg::ST_WR_CUR) && $changed(st_q) |-> $past(st_q) == rcb2_pkg::ST_WR_TAG)
		else $error("pointer update before info and tag writes");

	a_no_advance: assert property (@(posedge core_clk) disable iff (rst)
		mem_done && (st_q == rcb2_pkg::ST_WR_TAG) && (err_q || (tr_q && broadcast_flag_q))
		|=> st_q == rcb2_pkg::ST_IDLE)
		else $error("cursors advanced after error or broadcast transmit");

	a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
		$fell(int_n) |-> $past(mem_done && (st_q == rcb2_pkg::ST_WR_ICUR) && info_full
			&& ctrl_q[rcb2_pkg::CTRL_IRQ_BIT] && rt_block_done_enable) && block_done)
		else $error("interrupt without block done and both enables");

	a_flag_insert: assert property (@(posedge core_clk) disable iff (rst)
		$rose(mem_req) && (st_q == rcb2_pkg::ST_WR_INFO)
		|-> mem_wdata[rcb2_pkg::INFO_BROADCAST_FLAG_BIT] == (ext_broadcast_flag_enable && broadcast_flag_q))
		else $error("broadcast flag wrong in info word");

endmodule : rcb2_engine

/* File: rcb2_pkg.sv */
// Shared constants, state codes and decoding for the ring-mode-two storage engine.
package rcb2_pkg;

	// Engine states, one-hot.
	typedef enum logic [10:0] {
		ST_IDLE = 11'h001,
		ST_RD_CTRL = 11'h002,
		ST_RD_ORIG = 11'h004,
		ST_RD_CUR = 11'h008,
		ST_RD_INFO = 11'h010,
		ST_XFER = 11'h020,
		ST_WAIT_END = 11'h040,
		ST_WR_INFO = 11'h080,
		ST_WR_TAG = 11'h100,
		ST_WR_CUR = 11'h200,
		ST_WR_ICUR = 11'h400
	} rcb2_state_type;

	// Word offsets inside a four-word descriptor.
	localparam logic [1:0] DESC_CTRL_OFS = 2'h0;
	localparam logic [1:0] DESC_ORIG_OFS = 2'h1;
	localparam logic [1:0] DESC_CUR_OFS = 2'h2;
	localparam logic [1:0] DESC_INFO_OFS = 2'h3;

	// Command word fields.
	localparam int CMD_TR_BIT = 10;
	localparam int CMD_SA_LSB = 5;
	localparam int CMD_WC_LSB = 0;
	localparam logic [5:0] WC_ZERO_MEANS = 6'h20;

	// Descriptor control word fields.
	localparam int CTRL_RING1_BIT = 0;
	localparam int CTRL_RING2_BIT = 1;
	localparam int CTRL_PINGPONG_BIT = 2;
	localparam int CTRL_SIZE_LSB = 4;
	localparam int CTRL_IRQ_BIT = 8;
	localparam logic [3:0] SIZE_CODE_MIN = 4'h2;
	localparam logic [3:0] SIZE_CODE_MAX = 4'ha;

	// Position of the broadcast flag in the stored message-information word.
	localparam int INFO_BROADCAST_FLAG_BIT = 9;

	// Values after reset.
	localparam logic [5:0] LEFT_RESET = 6'h00;

	// Low-bit mask counted by a block-size code; codes outside the legal span are clamped.
	function automatic logic [15:0] rcb2_size_mask(input logic [3:0] code);
		logic [3:0] k;
		k = code;
		if (code < SIZE_CODE_MIN)
			k = SIZE_CODE_MIN;
		else if (code > SIZE_CODE_MAX)
			k = SIZE_CODE_MAX;
		rcb2_size_mask = (16'h0001 << k) - 16'h0001;
	endfunction : rcb2_size_mask

endpackage : rcb2_pkg

/* File: rcb2_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module rcb2_pair_buffer #(
	parameter int W = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Filling side.
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Draining side.
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);

	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic [W-1:0] e1_q;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 2'h0;
			out_valid <= 1'b0;
			in_ready <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			out_valid <= (cnt_d != 2'h0);
			in_ready <= (cnt_d != 2'h2);
		end
	end

	// The head always sits in out_data; the second entry only holds an overflow word.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			out_data <= '0;
			e1_q <= '0;
		end
		else if (pop)
		begin
			if (cnt_q == 2'h2)
				out_data <= e1_q;
			else if (push)
				out_data <= in_data;
		end
		else if (push)
		begin
			if (cnt_q == 2'h0)
				out_data <= in_data;
			else
				e1_q <= in_data;
		end
	end

endmodule : rcb2_pair_buffer

/* File: rcb2_info_step.sv */
// Next info cursor and full-count detection for the message-information ring.
`timescale 1ns/10ps
module rcb2_info_step #(
	parameter int AW = 16
) (
	// Current cursor and block-size code.
	input wire logic [AW-1:0] cursor,
	input wire logic [3:0] size_code,
	// Result.
	output logic [AW-1:0] next_cursor,
	output logic full
);

	logic [AW-1:0] mask;
	logic [AW-1:0] once;

	assign mask = AW'(rcb2_pkg::rcb2_size_mask(size_code));
	assign once = cursor + AW'(1);
	assign full = ((once & mask) == mask);
	// The counted low bits were zero at set-up, so clearing them restores the base.
	assign next_cursor = full ? (cursor & ~mask) : (cursor + AW'(2));

endmodule : rcb2_info_step

/* File: rcb2_ram_model.sv */
// Shared RAM model for the engine's memory port, answering after a random delay.
`timescale 1ns/10ps
module rcb2_ram_model (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Memory port.
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:65535];
	logic [15:0] wlog [$];
	integer seed = 32'hd7e3;
	int dly;
	// Read data toggles outside the ack cycle, so a stale word is never mistaken for an answer.
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mem_ack <= 1'b0;
			dly <= 0;
			mem_rdata <= 16'h5a5a;
		end
		else if (mem_req && !mem_ack && dly == 0)
		begin
			mem_ack <= 1'b1;
			dly <= $random(seed) & 3;
			if (mem_we)
			begin
				mem[mem_addr] <= mem_wdata;
				wlog.push_back(mem_addr);
			end
			else
				mem_rdata <= mem[mem_addr];
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && dly > 0)
				dly <= dly - 1;
		end
	end
endmodule : rcb2_ram_model

/* File: testbench.sv */
// Self-checking bench for the ring-mode-two storage engine.
`timescale 1ns/10ps
module testbench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0, cmd_broadcast = 1'b0, cmd_ready;
	logic [15:0] cmd_word = 16'h0000;
	logic [15:0] desc_table_base = 16'h0100;
	logic rt_block_done_enable = 1'b1, ext_broadcast_flag_enable = 1'b0;
	logic rx_valid = 1'b0, rx_ready, tx_valid, tx_ready = 1'b1;
	logic [15:0] rx_data = 16'h0000, tx_data;
	logic end_valid = 1'b0, end_error = 1'b0;
	logic [15:0] end_info = 16'h0000, end_time_tag = 16'h0000;
	logic mem_req, mem_we, mem_ack, int_clear = 1'b0, int_n, block_done, mode_skip, busy;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	logic [15:0] e_ctrl [64], e_orig [64], e_cur [64], e_ic [64];
	logic [31:0] r;
	integer seed = 32'hd7e3;
	int error_cnt = 0, cmp_count = 0, done_cnt = 0, skip_cnt = 0, tx_cnt = 0;

	rcb2_engine uut (.core_clk, .rst, .cmd_valid, .cmd_word, .cmd_broadcast, .cmd_ready,
		.desc_table_base, .rt_block_done_enable, .ext_broadcast_flag_enable, .rx_valid,
		.rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .end_valid, .end_error, .end_info,
		.end_time_tag, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
		.int_clear, .int_n, .block_done, .mode_skip, .busy);
	rcb2_ram_model ram (.core_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
		.mem_rdata);

	initial
	begin
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (block_done === 1'b1)
			done_cnt++;
		if (mode_skip === 1'b1)
			skip_cnt++;
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			tx_cnt++;
	end

	function automatic logic [15:0] size_mask(input logic [3:0] k);
		return (16'h0001 << k) - 16'h0001;
	endfunction : size_mask

	function automatic logic [15:0] info_exp(input logic [15:0] w, input logic b);
		info_exp = w;
		info_exp[rcb2_pkg::INFO_BROADCAST_FLAG_BIT] = b & ext_broadcast_flag_enable;
	endfunction : info_exp

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task complete_run;
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	task automatic set_desc(input logic tr, input logic [4:0] sa, input logic [15:0] c,
		input logic [15:0] o, input logic [15:0] i);
		logic [15:0] n;
		n = desc_table_base + {8'h00, tr, sa, 2'b00};
		ram.mem[n] = c;
		ram.mem[n + 16'h1] = o;
		ram.mem[n + 16'h2] = o;
		ram.mem[n + 16'h3] = i;
		e_ctrl[{tr, sa}] = c;
		e_orig[{tr, sa}] = o;
		e_cur[{tr, sa}] = o;
		e_ic[{tr, sa}] = i;
	endtask : set_desc

	task automatic run_msg(input logic tr, input logic [4:0] sa, input logic [4:0] wc,
		input logic bc, input logic er);
		logic [5:0] x;
		logic [15:0] n, cur, ic, info, tag, msk;
		logic [15:0] d [32];
		logic full, upd, skip;
		int cnt, k, got, d0, s0, t0, w0, w;
		x = {tr, sa};
		n = desc_table_base + {8'h00, x, 2'b00};
		cur = e_cur[x];
		ic = e_ic[x];
		msk = size_mask(e_ctrl[x][7:4]);
		skip = e_ctrl[x][rcb2_pkg::CTRL_PINGPONG_BIT];
		cnt = (wc == 5'h00) ? 32 : int'(wc);
		info = $random(seed);
		tag = $random(seed);
		d0 = done_cnt;
		s0 = skip_cnt;
		t0 = tx_cnt;
		w0 = ram.wlog.size();
		cmd_word <= {5'h00, tr, sa, wc};
		cmd_broadcast <= bc;
		cmd_valid <= 1'b1;
		@(posedge core_clk);
		for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge core_clk);
		check(k < 100, 1);
		cmd_valid <= 1'b0;
		if (!skip)
		begin
			if (!tr)
			begin
				rx_valid <= 1'b1;
				for (int i = 0; i < cnt; i++)
				begin
					d[i] = $random(seed);
					rx_data <= d[i];
					@(posedge core_clk);
					for (k = 0; k < 100 && rx_ready !== 1'b1; k++) @(posedge core_clk);
					check(k < 100, 1);
				end
				rx_valid <= 1'b0;
			end
			else if (!bc)
			begin
				// Random stalls on the transmit side push the two-entry buffer to its limit.
				for (got = 0, k = 0; got < cnt && k < 3000; k++)
				begin
					@(posedge core_clk);
					if (tx_valid === 1'b1 && tx_ready === 1'b1)
					begin
						check(tx_data, ram.mem[cur + got]);
						got++;
					end
					tx_ready <= 1'($random(seed));
				end
				check(got, cnt);
			end
			end_valid <= 1'b1;
			end_error <= er;
			end_info <= info;
			end_time_tag <= tag;
			@(posedge core_clk);
			end_valid <= 1'b0;
		end
		@(posedge core_clk);
		for (k = 0; k < 400 && cmd_ready !== 1'b1; k++) @(posedge core_clk);
		check(k < 400, 1);
		repeat (3) @(posedge core_clk);
		if (skip)
		begin
			check(skip_cnt - s0, 1);
			check(ram.wlog.size() - w0, 0);
			return;
		end
		upd = !er && !(tr && bc);
		full = upd && (((ic + 16'h0001) & msk) == msk);
		if (!tr)
			for (int i = 0; i < cnt; i++) check(ram.mem[cur + i], d[i]);
		check(ram.mem[ic], info_exp(info, bc));
		check(ram.mem[ic + 16'h1], tag);
		w = ram.wlog.size();
		check(ram.wlog[w - (upd ? 4 : 2)], ic);
		if (upd)
			check(ram.wlog[w - 1], n + 16'h3);
		if (full)
			ic = ic & ~msk;
		else if (upd)
			ic = ic + 16'h2;
		if (full)
			cur = e_orig[x];
		else if (upd)
			cur = cur + 16'(cnt);
		check(ram.mem[n + 16'h2], cur);
		check(ram.mem[n + 16'h3], ic);
		check(done_cnt - d0, full);
		check(tx_cnt - t0, (tr && !bc) ? cnt : 0);
		check(int_n, !(full && e_ctrl[x][8] && rt_block_done_enable));
		e_cur[x] = cur;
		e_ic[x] = ic;
		if (int_n === 1'b0)
		begin
			int_clear <= 1'b1;
			@(posedge core_clk);
			int_clear <= 1'b0;
			repeat (2) @(posedge core_clk);
			check(int_n, 1'b1);
		end
	endtask : run_msg

	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		for (int i = 0; i < 4096; i++) ram.mem[16'h3000 + i] = $random(seed);
		set_desc(0, 5'h03, 16'h0123, 16'h2000, 16'h8000);
		run_msg(0, 5'h03, 5'h04, 0, 0);
		run_msg(0, 5'h03, 5'h00, 0, 0);
		run_msg(0, 5'h03, 5'h02, 0, 1);
		run_msg(0, 5'h03, 5'h02, 0, 0);
		$display("test rx_block done");
		set_desc(1, 5'h07, 16'h0132, 16'h3000, 16'h8400);
		run_msg(1, 5'h07, 5'h03, 0, 0);
		run_msg(1, 5'h07, 5'h03, 1, 0);
		run_msg(1, 5'h07, 5'h02, 0, 0);
		$display("test tx_broadcast_flag done");
		rt_block_done_enable <= 1'b0;
		ext_broadcast_flag_enable <= 1'b1;
		run_msg(0, 5'h03, 5'h01, 1, 0);
		run_msg(0, 5'h03, 5'h01, 0, 0);
		$display("test masked done");
		set_desc(0, 5'h0a, 16'h0026, 16'h2400, 16'h8c00);
		run_msg(0, 5'h0a, 5'h01, 0, 0);
		$display("test skip done");
		rt_block_done_enable <= 1'b1;
		ext_broadcast_flag_enable <= 1'b0;
		set_desc(0, 5'h11, 16'h01a2, 16'h4000, 16'h8800);
		repeat (512) run_msg(0, 5'h11, 5'h01, 0, 0);
		$display("test big_block done");
		repeat (40)
		begin
			r = $random(seed);
			run_msg(r[0], r[0] ? 5'h07 : 5'h03, r[8:4], r[1], r[11:9] == 3'h0);
		end
		$display("test random done");
		complete_run;
	end

	// The tests need about 30000 cycles; the limit is 100000 cycles.
	initial
	begin
		#2000000;
		error_cnt++;
		complete_run;
	end
endmodule : testbench
